// ---- core/cmd_port_defines.svh ----
// constants for the two-cycle command port
`ifndef CMD_PORT_DEFINES_SVH
`define CMD_PORT_DEFINES_SVH
`define CLK_PERIOD_PS     5000
`define EMR_SETTLE_CLKS   200
`define INIT_REFRESH_MIN  2
`define LA_LSB            0
`define LA_MSB            6
`define MR_ZERO_LSB       8
`define MR_ZERO_MSB       14
`define VW0_BIT           14
`define VW1_BIT           13
`define FIFO_DEPTH        8
`define DATA_W            18
`define ADDR_W            15
`define BANK_W            2
`define WCNT_W            8
`define MR_BANK_REGULAR   2'h0
`define MR_BANK_EXTENDED  2'h1
`define BL_FIELD_LSB      0
`define BL_FIELD_MSB      2
`define BL_CODE_TWO       3'h1
`define FREE_QS_BIT       5
`define DLL_ENABLE_BIT    0
`endif

// ---- core/cmd_port_pkg.sv ----
// types shared by the command port modules
package cmd_port_pkg;
  typedef enum logic [4:0] {
    ST_INIT     = 5'h01,
    ST_IDLE     = 5'h02,
    ST_ACT_RD   = 5'h04,
    ST_ACT_WR   = 5'h08,
    ST_SLEEP    = 5'h10
  } cmd_state_t;
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_MODE  = 2'h2,
    OP_REF   = 2'h3
  } op_kind_t;
endpackage : cmd_port_pkg

// ---- core/op_stream_if.sv ----
// valid/ready stream of decoded operations between port and fifo
`timescale 1ns/1ps
`include "cmd_port_defines.svh"
interface op_stream_if;
  logic                                      valid;
  logic                                      ready;
  logic [`BANK_W+`ADDR_W+`LA_MSB+1+3+2-1:0]  data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : op_stream_if

// ---- core/op_fifo.sv ----
// parameterised flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module op_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // honest full and empty from the occupancy count
  always_comb begin
    in_ready_out  = (cnt_reg != (AW+1)'(DEPTH));
    out_valid_out = (cnt_reg != '0);
    out_data_out  = mem_reg[rd_reg];
    push          = in_valid_in && in_ready_out;
    pop           = out_valid_out && out_ready_in;
    mem_next      = mem_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_in;
    end
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule : op_fifo

// ---- core/cmd_port.sv ----
// command decoder and sequencer of a four-bank ddr memory device
// Behaviour
// - normal operation 200 clocks after extended write
// - data outputs stay released during power-up
// - commands sampled on rising clock edge
// - first command: read/write activate or deselect
// - second command next clock: latch or refresh
// - mode write: read-activate then zero-bit opcode
// - top address bits pick written write length
// - power_down_n rising exits sleep without clock
// - free-running mode toggles read strobe every clock once ready
// - read data edge-aligned with read strobe
`timescale 1ns/1ps
`include "cmd_port_defines.svh"
module cmd_port (
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  // command pins, from outside the clock domain
  input  wire logic                link_clk_in,
  input  wire logic                chip_select_n_in,
  input  wire logic                function_select_in,
  input  wire logic                power_down_n_in,
  input  wire logic [`BANK_W-1:0]  bank_in,
  input  wire logic [`ADDR_W-1:0]  address_in,
  // read data pins, output enable low while driving
  input  wire logic                read_valid_in,
  input  wire logic [`DATA_W-1:0]  read_word_in,
  output logic [`DATA_W-1:0]       read_data_out,
  output logic                     read_data_oe_n_out,
  output logic                     read_data_strobe_out,
  // decoded operation stream to the array
  output logic                     op_valid_out,
  input  wire logic                op_ready_in,
  output logic [1:0]               op_kind_out,
  output logic [`BANK_W-1:0]       op_bank_out,
  output logic [`ADDR_W-1:0]       op_upper_address_out,
  output logic [`LA_MSB:0]         op_lower_address_out,
  output logic [2:0]               op_word_count_out,
  // status
  output logic                     ready_out,
  output logic                     sleeping_out,
  output logic                     cmd_dropped_out,
  output logic [`BANK_W+`ADDR_W-1:0] mode_regular_out,
  output logic [`BANK_W+`ADDR_W-1:0] mode_extended_out
);
  localparam int OPW = `BANK_W + `ADDR_W + `LA_MSB + 1 + 3 + 2;

  // two-flop synchronisers for every command pin
  logic [`BANK_W+`ADDR_W+2:0] pin_s1_reg, pin_s2_reg, pin_s1_next;
  logic                       pdn_s1_reg, pdn_s2_reg;
  always_comb begin
    pin_s1_next = {link_clk_in, chip_select_n_in, function_select_in, bank_in, address_in};
  end
  always_ff @(posedge core_clk_in) begin
    pin_s1_reg <= pin_s1_next;
    pin_s2_reg <= pin_s1_reg;
    pdn_s1_reg <= power_down_n_in;
    pdn_s2_reg <= pdn_s1_reg;
  end

  logic                sclk, scs_n, sfn;
  logic [`BANK_W-1:0]  sbank;
  logic [`ADDR_W-1:0]  saddr;
  always_comb begin
    {sclk, scs_n, sfn, sbank, saddr} = pin_s2_reg;
  end

  // word count for a write from the two length bits
  function automatic logic [2:0] write_words(input logic bl_two, input logic vw0,
                                             input logic vw1);
    if (bl_two) begin
      write_words = vw0 ? 3'h1 : 3'h2;
    end else begin
      case ({vw0, vw1})
        2'b10:   write_words = 3'h4;
        2'b01:   write_words = 3'h2;
        2'b11:   write_words = 3'h1;
        default: write_words = 3'h0;
      endcase
    end
  endfunction : write_words

  // sequencer state
  cmd_port_pkg::cmd_state_t   state_reg, state_next;
  logic                       clk_prev_reg, clk_prev_next;
  logic                       pdn_prev_reg, pdn_prev_next;
  logic [`BANK_W-1:0]         bank_reg, bank_next;
  logic [`ADDR_W-1:0]         ua_reg, ua_next;
  logic [`WCNT_W-1:0]         settle_reg, settle_next;
  logic [1:0]                 refs_reg, refs_next;
  logic                       emr_done_reg, emr_done_next, mr_done_reg, mr_done_next;
  logic                       ready_reg, ready_next, drop_reg, drop_next;
  logic                       self_ref_reg, self_ref_next;
  logic [`BANK_W+`ADDR_W-1:0] mr_reg, mr_next, emr_reg, emr_next;
  logic                       push;
  logic [OPW-1:0]             push_data;
  logic                       rise, pdn_rise;
  logic                       bl_two;

  op_stream_if fifo_in ();

  always_comb begin
    rise          = sclk && !clk_prev_reg;
    pdn_rise      = pdn_s2_reg && !pdn_prev_reg;
    clk_prev_next = sclk;
    pdn_prev_next = pdn_s2_reg;
    bl_two        = (mr_reg[`BL_FIELD_MSB:`BL_FIELD_LSB] == `BL_CODE_TWO);
    state_next    = state_reg;
    bank_next     = bank_reg;
    ua_next       = ua_reg;
    refs_next     = refs_reg;
    emr_done_next = emr_done_reg;
    mr_done_next  = mr_done_reg;
    mr_next       = mr_reg;
    emr_next      = emr_reg;
    self_ref_next = self_ref_reg;
    drop_next     = 1'b0;
    push          = 1'b0;
    push_data     = '0;
    // settle counter counts link edges, saturating, after each extended mode write
    settle_next   = settle_reg;
    if (rise && emr_done_reg && settle_reg < `WCNT_W'(`EMR_SETTLE_CLKS)) begin
      settle_next = `WCNT_W'(settle_reg + 1'b1);
    end
    ready_next = ready_reg || (emr_done_reg && mr_done_reg
                 && refs_reg >= 2'(`INIT_REFRESH_MIN)
                 && settle_reg >= `WCNT_W'(`EMR_SETTLE_CLKS));
    case (state_reg)
      cmd_port_pkg::ST_INIT, cmd_port_pkg::ST_IDLE: begin
        if (!pdn_s2_reg && ready_reg && scs_n) begin
          state_next = cmd_port_pkg::ST_SLEEP;
        end else if (rise && !scs_n) begin
          bank_next  = sbank;
          ua_next    = saddr;
          state_next = sfn ? cmd_port_pkg::ST_ACT_RD : cmd_port_pkg::ST_ACT_WR;
        end
      end
      cmd_port_pkg::ST_ACT_RD, cmd_port_pkg::ST_ACT_WR: begin
        if (rise) begin
          state_next = ready_reg ? cmd_port_pkg::ST_IDLE : cmd_port_pkg::ST_INIT;
          if (scs_n) begin
            push      = 1'b1;
            push_data = {(state_reg == cmd_port_pkg::ST_ACT_WR)
                           ? cmd_port_pkg::OP_WRITE : cmd_port_pkg::OP_READ,
                         bank_reg, ua_reg, saddr[`LA_MSB:`LA_LSB],
                         (state_reg == cmd_port_pkg::ST_ACT_WR)
                           ? write_words(bl_two, saddr[`VW0_BIT], saddr[`VW1_BIT])
                           : (bl_two ? 3'h2 : 3'h4)};
          end else if (state_reg == cmd_port_pkg::ST_ACT_RD) begin
            if (saddr[`MR_ZERO_MSB:`MR_ZERO_LSB] == '0) begin
              if (sbank == `MR_BANK_EXTENDED) begin
                emr_next      = {sbank, saddr};
                emr_done_next = 1'b1;
                settle_next   = '0;
              end else begin
                mr_next      = {sbank, saddr};
                mr_done_next = 1'b1;
              end
            end else begin
              drop_next = 1'b1;
            end
          end else begin
            push      = 1'b1;                                              // refresh
            push_data = {cmd_port_pkg::OP_REF, bank_reg, ua_reg, 7'h00, 3'h0};
            if (refs_reg != 2'h3) begin
              refs_next = 2'(refs_reg + 1'b1);
            end
            self_ref_next = 1'b1;
            if (!pdn_s2_reg) begin
              state_next = cmd_port_pkg::ST_SLEEP;
            end
          end
          if (push && !fifo_in.ready) begin
            drop_next = 1'b1;                                              // fifo full
          end
        end
      end
      cmd_port_pkg::ST_SLEEP: begin
        if (pdn_rise && scs_n) begin
          state_next    = ready_reg ? cmd_port_pkg::ST_IDLE : cmd_port_pkg::ST_INIT;
          self_ref_next = 1'b0;
        end
      end
      default: state_next = cmd_port_pkg::ST_INIT;
    endcase
    if (state_reg != cmd_port_pkg::ST_ACT_WR || !rise || scs_n) begin
      self_ref_next = (state_next == cmd_port_pkg::ST_SLEEP) && self_ref_next;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg    <= cmd_port_pkg::ST_INIT;
      clk_prev_reg <= 1'b1;
      pdn_prev_reg <= 1'b1;
      bank_reg     <= '0;
      ua_reg       <= '0;
      settle_reg   <= '0;
      refs_reg     <= '0;
      emr_done_reg <= 1'b0;
      mr_done_reg  <= 1'b0;
      ready_reg    <= 1'b0;
      drop_reg     <= 1'b0;
      self_ref_reg <= 1'b0;
      mr_reg       <= '0;
      emr_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      clk_prev_reg <= clk_prev_next;
      pdn_prev_reg <= pdn_prev_next;
      bank_reg     <= bank_next;
      ua_reg       <= ua_next;
      settle_reg   <= settle_next;
      refs_reg     <= refs_next;
      emr_done_reg <= emr_done_next;
      mr_done_reg  <= mr_done_next;
      ready_reg    <= ready_next;
      drop_reg     <= drop_next;
      self_ref_reg <= self_ref_next;
      mr_reg       <= mr_next;
      emr_reg      <= emr_next;
    end
  end

  // only a write with a zero word count is held back, so its cells keep their data;
  // refreshes carry no words but must still reach the array
  always_comb begin
    fifo_in.valid = push && (push_data[2:0] != 3'h0
                    || push_data[OPW-1 -: 2] != cmd_port_pkg::OP_WRITE);
    fifo_in.data  = push_data;
  end

  op_fifo #(
    .WIDTH (OPW),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (fifo_in.valid),
    .in_ready_out  (fifo_in.ready),
    .in_data_in    (fifo_in.data),
    .out_valid_out (op_valid_out),
    .out_ready_in  (op_ready_in),
    .out_data_out  ({op_kind_out, op_bank_out, op_upper_address_out,
                     op_lower_address_out, op_word_count_out})
  );

  // read return: strobe toggles per word, or every clock in free-running mode once ready
  logic [`DATA_W-1:0] rdata_reg, rdata_next;
  logic               qs_reg, qs_next, oe_n_reg, oe_n_next;
  logic               free_qs;
  always_comb begin
    free_qs    = emr_reg[`FREE_QS_BIT] && ready_reg;
    rdata_next = rdata_reg;
    qs_next    = qs_reg;
    oe_n_next  = 1'b1;
    if (ready_reg && read_valid_in) begin
      rdata_next = read_word_in;
      qs_next    = !qs_reg;
      oe_n_next  = 1'b0;
    end else if (free_qs) begin
      qs_next = !qs_reg;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
      qs_reg    <= 1'b0;
      oe_n_reg  <= 1'b1;
    end else begin
      rdata_reg <= rdata_next;
      qs_reg    <= qs_next;
      oe_n_reg  <= oe_n_next;
    end
  end

  // status outputs, all from flops
  always_comb begin
    read_data_out        = rdata_reg;
    read_data_strobe_out = qs_reg;
    read_data_oe_n_out   = oe_n_reg;
    ready_out            = ready_reg;
    sleeping_out         = (state_reg == cmd_port_pkg::ST_SLEEP);
    cmd_dropped_out      = drop_reg;
    mode_regular_out     = mr_reg;
    mode_extended_out    = emr_reg;
  end
endmodule : cmd_port

// ---- sim/cmd_port_checker.sv ----
// concurrent checks on the command port outputs
`timescale 1ns/1ps
`include "cmd_port_defines.svh"
module cmd_port_checker (
  // clock and reset
  input wire logic                        core_clk_in,
  input wire logic                        rst_in,
  // command pins
  input wire logic                        link_clk_in,
  input wire logic                        chip_select_n_in,
  input wire logic                        function_select_in,
  input wire logic                        power_down_n_in,
  input wire logic [`BANK_W-1:0]          bank_in,
  input wire logic [`ADDR_W-1:0]          address_in,
  // read data
  input wire logic                        read_valid_in,
  input wire logic [`DATA_W-1:0]          read_word_in,
  input wire logic [`DATA_W-1:0]          read_data_out,
  input wire logic                        read_data_oe_n_out,
  input wire logic                        read_data_strobe_out,
  // operation stream
  input wire logic                        op_valid_out,
  input wire logic                        op_ready_in,
  input wire logic [1:0]                  op_kind_out,
  input wire logic [`BANK_W-1:0]          op_bank_out,
  input wire logic [`ADDR_W-1:0]          op_upper_address_out,
  input wire logic [`LA_MSB:0]            op_lower_address_out,
  input wire logic [2:0]                  op_word_count_out,
  // status
  input wire logic                        ready_out,
  input wire logic                        sleeping_out,
  input wire logic                        cmd_dropped_out,
  input wire logic [`BANK_W+`ADDR_W-1:0]  mode_regular_out,
  input wire logic [`BANK_W+`ADDR_W-1:0]  mode_extended_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_init_released: assert property (!ready_out |-> read_data_oe_n_out)
    else $error("read pins driven before init done");
  a_read_aligned: assert property (ready_out && read_valid_in |=>
    !read_data_oe_n_out && read_data_out == $past(read_word_in))
    else $error("read word not presented one cycle later");
  a_strobe_per_word: assert property (ready_out && read_valid_in &&
    !mode_extended_out[`FREE_QS_BIT] |=> $changed(read_data_strobe_out))
    else $error("read strobe did not toggle with word");
  a_free_strobe: assert property (ready_out && !sleeping_out &&
    mode_extended_out[`FREE_QS_BIT] |-> ##[1:2] $changed(read_data_strobe_out))
    else $error("free strobe stood still");
  a_ext_opcode: assert property ($changed(mode_extended_out) |->
    mode_extended_out[14:8] == 7'h00) else $error("extended mode took nonzero high bits");
  a_reg_opcode: assert property ($changed(mode_regular_out) |->
    mode_regular_out[14:8] == 7'h00) else $error("regular mode took nonzero high bits");
  a_write_length: assert property (op_valid_out && op_kind_out == 2'h1 |->
    op_word_count_out inside {3'h1, 3'h2, 3'h4}) else $error("bad write word count");
  a_op_hold: assert property (op_valid_out && !op_ready_in |=> op_valid_out &&
    $stable({op_kind_out, op_bank_out, op_upper_address_out, op_lower_address_out}))
    else $error("operation changed while stalled");
  a_sleep_exit: assert property (sleeping_out && power_down_n_in &&
    chip_select_n_in |-> ##[1:4] !sleeping_out) else $error("sleep not left");
endmodule : cmd_port_checker
bind cmd_port cmd_port_checker cmd_port_checker_i (.*);

// ---- sim/ctrl_model.sv ----
// behavioural memory controller issuing two-cycle commands
`timescale 1ns/1ps
module ctrl_model (
  // command pins towards the device
  output logic        link_clk_out,
  output logic        cs_n_out,
  output logic        fn_out,
  output logic        pd_n_out,
  output logic [1:0]  bank_out,
  output logic [14:0] addr_out
);
  // controller clock runs free, pins idle deselected and awake
  initial begin
    link_clk_out = 1'b0;
    cs_n_out = 1'b1;
    fn_out = 1'b0;
    pd_n_out = 1'b1;
    bank_out = 2'h0;
    addr_out = 15'h0000;
    forever #24 link_clk_out = ~link_clk_out;
  end
  // pins move on the falling edge so the rising sample is clean
  // activate, then second command on the very next edge
  task automatic send(input logic fn, input logic [1:0] bk, input logic [14:0] up,
                      input logic cs2, input logic pd2, input logic [1:0] bk2,
                      input logic [14:0] lo);
    // no command before the clock has run stable for 200 us
    while ($time < 200_000) @(negedge link_clk_out);
    @(negedge link_clk_out);
    cs_n_out = 1'b0;
    fn_out = fn;
    bank_out = bk;
    addr_out = up;
    @(negedge link_clk_out);
    cs_n_out = cs2;
    pd_n_out = pd2; // low here enters self refresh in its window
    fn_out = ~fn;
    bank_out = bk2;
    addr_out = lo;
    @(negedge link_clk_out);
    // released bank and address lines show the inverse; fn_out keeps its second-command value
    cs_n_out = 1'b1;
    bank_out = ~bk2;
    addr_out = ~lo;
  endtask : send
  // sleep request only from idle with chip select high
  task automatic set_pd(input logic v);
    @(negedge link_clk_out);
    pd_n_out = v;
  endtask : set_pd
endmodule : ctrl_model

// ---- sim/test_cmd_port.sv ----
// self-checking bench for the command port
`timescale 1ns/1ps
`include "cmd_port_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_cmd_port;
  logic        core_clk_in = 1'b0, rst_in = 1'b1, read_valid_in = 1'b0, op_ready_in = 1'b0;
  logic [17:0] read_word_in = 18'h00000, read_data_out;
  logic        link_clk_in, chip_select_n_in, function_select_in, power_down_n_in;
  logic [1:0]  bank_in, op_bank_out, op_kind_out;
  logic [14:0] address_in, op_upper_address_out;
  logic [6:0]  op_lower_address_out;
  logic [2:0]  op_word_count_out;
  logic        read_data_oe_n_out, read_data_strobe_out, op_valid_out, ready_out;
  logic        sleeping_out, cmd_dropped_out, hold = 1'b0, quiet = 1'b0;
  logic [16:0] mode_regular_out, mode_extended_out;
  logic [31:0] rnd = 32'h0001033F, seed = 32'h0001033F;
  logic [28:0] exp_q[$], msk_q[$], e, m;
  int          error_cnt = 0, num_checks = 0, drops = 0, d0;
  wire  [28:0] got = {op_kind_out, op_bank_out, op_upper_address_out,
                      op_lower_address_out, op_word_count_out};
  cmd_port cmd_port_i (.*);
  ctrl_model ctrl_model_i (.link_clk_out(link_clk_in), .cs_n_out(chip_select_n_in),
    .fn_out(function_select_in), .pd_n_out(power_down_n_in), .bank_out(bank_in),
    .addr_out(address_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic results();
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic push(input logic [28:0] ev, input logic [28:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
  endtask : push
  task automatic mode(input logic [1:0] bk, input logic [14:0] op);
    ctrl_model_i.send(1'b1, bk, 15'h7FFF, 1'b0, 1'b1, bk, op);
    `CHK("mode reg", {bk, op}, bk == 2'h1 ? mode_extended_out : mode_regular_out)
  endtask : mode
  task automatic refresh(input logic pd);
    push({2'h3, 27'h0}, {2'h3, 27'h0});
    ctrl_model_i.send(1'b0, 2'h2, 15'h1234, 1'b0, pd, 2'h1, 15'h0000);
  endtask : refresh
  task automatic rd(input logic kept);
    seed = xs(seed);
    if (kept) push({2'h0, seed[1:0], seed[16:2], seed[23:17], 3'h0}, 29'h1FFFFFF8);
    ctrl_model_i.send(1'b1, seed[1:0], seed[16:2], 1'b1, 1'b1, 2'h0, {8'h00, seed[23:17]});
  endtask : rd
  // written words follow the two top bits of the latch address
  task automatic wr(input logic [1:0] vw, input logic bl2);
    logic [2:0] n;
    seed = xs(seed);
    n = bl2 ? (vw[1] ? 3'h1 : 3'h2) : (vw == 2'h2 ? 3'h4 : vw == 2'h1 ? 3'h2 : {2'h0, vw[0]});
    if (n != 3'h0) push({2'h1, seed[1:0], seed[16:2], seed[23:17], n}, 29'h1FFFFFFF);
    ctrl_model_i.send(1'b0, seed[1:0], seed[16:2], 1'b1, 1'b1, 2'h3, {vw, 6'h00, seed[23:17]});
  endtask : wr
  task automatic drain();
    for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(posedge core_clk_in);
    `CHK("pending ops", 0, exp_q.size())
  endtask : drain
  initial forever #2.5 core_clk_in = ~core_clk_in;
  // hang guard: the 200 us start-up pause plus several times the command run
  initial begin
    #300000;
    error_cnt++;
    results();
  end
  // random read words and a stalling drain side, off the sampling edge
  always @(negedge core_clk_in) begin
    rnd <= xs(rnd);
    read_valid_in <= ready_out & ~sleeping_out & ~quiet & rnd[1];
    read_word_in <= rnd[31:14];
    op_ready_in <= ~hold & rnd[0];
  end
  // result side: every accepted operation is matched to the oldest note
  always @(posedge core_clk_in) begin
    if (cmd_dropped_out === 1'b1) drops++;
    if (!rst_in && op_valid_out === 1'b1 && op_ready_in === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spare op", 1'b0, 1'b1)
      else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        `CHK("op", e & m, got & m)
      end
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_in);
    @(negedge core_clk_in) rst_in = 1'b0;
    `CHK("oe_n at start", 1'b1, read_data_oe_n_out)
    // steps in shuffled order, refreshes well apart
    mode(2'h0, 15'h0002);
    refresh(1'b1);
    mode(2'h1, 15'h0001);
    refresh(1'b1);
    repeat (145) @(negedge link_clk_in);
    `CHK("ready early", 1'b0, ready_out)
    repeat (60) @(negedge link_clk_in);
    `CHK("ready late", 1'b1, ready_out)
    for (int i = 0; i < 4; i++) wr(i[1:0], 1'b0);
    repeat (3) rd(1'b1);
    d0 = drops;
    ctrl_model_i.send(1'b1, 2'h0, 15'h0000, 1'b0, 1'b1, 2'h0, 15'h0101);
    repeat (4) @(negedge link_clk_in);
    `CHK("mode refused", d0 + 1, drops)
    `CHK("mode kept", 17'h00002, mode_regular_out)
    mode(2'h0, 15'h0001);
    for (int i = 0; i < 4; i++) wr(i[1:0], 1'b1);
    drain();
    // fill the buffer until it refuses, then let it drain
    hold = 1'b1;
    d0 = drops;
    for (int i = 0; i < 9; i++) rd(i < 8);
    repeat (4) @(negedge link_clk_in);
    `CHK("full refused", d0 + 1, drops)
    hold = 1'b0;
    drain();
    quiet = 1'b1;
    repeat (8) @(negedge core_clk_in);
    ctrl_model_i.set_pd(1'b0);
    repeat (4) @(negedge link_clk_in);
    `CHK("sleep entry", 1'b1, sleeping_out)
    ctrl_model_i.set_pd(1'b1);
    repeat (2) @(negedge link_clk_in);
    `CHK("sleep exit", 1'b0, sleeping_out)
    refresh(1'b0);
    repeat (3) @(negedge link_clk_in);
    `CHK("self refresh", 1'b1, sleeping_out)
    ctrl_model_i.set_pd(1'b1);
    repeat (2) @(negedge link_clk_in);
    `CHK("self refresh exit", 1'b0, sleeping_out)
    quiet = 1'b0;
    mode(2'h1, 15'h0021);
    repeat (60) @(negedge core_clk_in);
    drain();
    results();
  end
endmodule : test_cmd_port
